// >>> host_link_model.sv
// host side of the serial link: bit clock, frame sync and per-pin slot capture
`timescale 1ns/1ps
module host_link_model (
  output logic      bclk,
  output logic      fsync,
  input  wire logic first_data_output,
  input  wire logic first_data_output_oe,
  input  wire logic second_data_output,
  input  wire logic second_data_output_oe
);
  logic [31:0] cap   [2];
  int          cnt   [2];
  int          first [2];

  initial begin
    bclk  = 1'b0;
    fsync = 1'b0;
  end

  // only bits the device really drives are taken, so a released pin never counts
  task automatic grab(input int p, input int r, input logic d);
    if (cnt[p] == 0) begin
      first[p] = r;
    end
    cap[p] = {cap[p][30:0], d};
    cnt[p]++;
  endtask : grab

  // bit clock runs only inside frames and stands low between them
  task automatic frame(input int nbits, input logic [1:0] fmt);
    for (int p = 0; p < 2; p++) begin
      cap[p]   = '0;
      cnt[p]   = 0;
      first[p] = -1;
    end
    // step off the system clock edge so the synchronisers never race the pins
    #2;
    for (int r = 0; r < nbits; r++) begin
      bclk = 1'b0;
      if (fmt == 2'h0 || fmt == 2'h3) begin
        fsync = (r == 0);
      end else begin
        fsync = (r >= nbits / 2) ^ (fmt == 2'h2);
      end
      #80;
      bclk = 1'b1;
      if (first_data_output_oe === 1'b1) begin
        grab(0, r, first_data_output);
      end
      if (second_data_output_oe === 1'b1) begin
        grab(1, r, second_data_output);
      end
      #80;
    end
    bclk = 1'b0;
  endtask : frame
endmodule : host_link_model

// >>> sample_fifo.sv
// synchronous sample fifo with registered input ready
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  sample_fifo_if.fifo port
);
  import serial_tx_ch2_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        in_ready;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  assign port.out_valid = (st.count != '0);
  assign port.out_data  = st.mem[st.rd_ptr];
  assign port.in_ready  = st.in_ready;

  always_comb begin
    next_st = st;
    push    = port.in_valid && st.in_ready;
    pop     = port.out_ready && (st.count != '0);
    if (push) begin
      next_st.mem[st.wr_ptr] = port.in_data;
      next_st.wr_ptr = (st.wr_ptr == LAST_C) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == LAST_C) ? '0 : st.rd_ptr + 1'b1;
    end
    next_st.count    = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // ready is a flop fed from the next count, so the source sees full in the same cycle, never late
    next_st.in_ready = (next_st.count < DEPTH_C);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st          <= '0;
      st.in_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.count <= DEPTH_C) else $error("fifo count above depth");

endmodule : sample_fifo

// >>> sample_fifo_if.sv
// valid/ready carrier between the slot logic and its sample fifo
`timescale 1ns/1ps
interface sample_fifo_if #(parameter int WIDTH = 32);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface : sample_fifo_if

// >>> serial_tx_ch2.sv
// channel 2 transmit configuration register and slot placement on the serial port
`timescale 1ns/1ps
// What this block does
// - 8-bit config register 0x1f, resets 0x21
// - bits 7-6 reserved, written zero, read zero
// - enable bit 5 low tri-states channel 2
// - enable high sends microphone channel 2 samples
// - 5-bit slot select, resets to slot 1
// - values 0-15: TDM slot, left half slot
// - values 16-31: TDM slot, right slot minus 16
// - pin-select bit 1 routes to first/second pin
module serial_tx_ch2 #(
  parameter int SAMPLE_W = serial_tx_ch2_pkg::SAMPLE_BITS,
  parameter int DEPTH    = serial_tx_ch2_pkg::FIFO_DEPTH
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [7:0]          reg_rdata,
  input  wire logic                bclk,
  input  wire logic                fsync,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  input  wire logic                sample_valid,
  output logic                     sample_ready,
  output logic                     first_data_output,
  output logic                     first_data_output_oe,
  output logic                     second_data_output,
  output logic                     second_data_output_oe
);
  import serial_tx_ch2_pkg::*;

  typedef struct packed {
    logic [7:0]       ch2_cfg;
    logic             channel2_pin_select;
    logic [1:0]       fmt;
    logic [1:0]       wl_code;
    logic [7:0]       rdata;
    logic             bclk_s1;
    logic             bclk_s2;
    logic             bclk_d;
    logic             fsync_s1;
    logic             fsync_s2;
    logic             fsync_prev;
    link_state_t      state;
    logic [IDX_W-1:0] count;
    logic [IDX_W-1:0] period;
    logic             half;
    logic [SAMPLE_W-1:0] word;
    logic             underrun;
    logic             pop;
    logic             out1;
    logic             out1_oe;
    logic             out2;
    logic             out2_oe;
  } tx_state_t;

  tx_state_t st;
  tx_state_t next_st;

  sample_fifo_if #(.WIDTH(SAMPLE_W)) fifo_link ();

  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .port    (fifo_link.fifo)
  );

  assign fifo_link.in_valid  = sample_valid;
  assign fifo_link.in_data   = sample_data;
  assign fifo_link.out_ready = st.pop;
  assign sample_ready        = fifo_link.in_ready;

  assign reg_rdata             = st.rdata;
  assign first_data_output     = st.out1;
  assign first_data_output_oe  = st.out1_oe;
  assign second_data_output    = st.out2;
  assign second_data_output_oe = st.out2_oe;

  // decoded configuration and link edges
  logic                channel2_output_enable;
  logic [SLOT_W-1:0]   channel2_slot_select;
  logic                rise;
  logic                fall;
  logic                frame_event;
  logic [IDX_W-1:0]    lead_idx;
  logic                lead_half;
  logic [5:0]          wl;
  logic [SLOT_W-1:0]   slot_eff;
  logic [IDX_W-1:0]    slot_start;
  logic [IDX_W:0]      slot_end;
  logic                half_ok;
  logic                active;
  logic [4:0]          bitpos;
  logic [SAMPLE_W-1:0] load_word;
  logic                tx_bit;

  assign channel2_output_enable = st.ch2_cfg[CH2_EN_BIT];
  assign channel2_slot_select   = st.ch2_cfg[SLOT_LSB +: SLOT_W];
  assign rise = st.bclk_s2 && !st.bclk_d;
  assign fall = !st.bclk_s2 && st.bclk_d;
  assign wl   = word_bits(st.wl_code);

  always_comb begin
    // tdm marks a frame on the rising fsync, i2s and lj on either edge
    if (st.fmt == FMT_I2S || st.fmt == FMT_LJ) begin
      frame_event = (st.fsync_s2 != st.fsync_prev);
    end else begin
      frame_event = st.fsync_s2 && !st.fsync_prev;
    end
    // lj puts the msb on the fsync edge itself, so it is sent one bit ahead
    if (st.fmt == FMT_LJ && (st.count + 1'b1 == st.period)) begin
      lead_idx  = '0;
      lead_half = !st.half;
    end else if (st.fmt == FMT_LJ) begin
      lead_idx  = st.count + 1'b1;
      lead_half = st.half;
    end else begin
      lead_idx  = st.count;
      lead_half = st.half;
    end
  end

  always_comb begin
    if (st.fmt == FMT_I2S || st.fmt == FMT_LJ) begin
      slot_eff = {1'b0, channel2_slot_select[HALF_BIT-1:0]};
      half_ok  = (lead_half == channel2_slot_select[HALF_BIT]);
    end else begin
      slot_eff = channel2_slot_select;
      half_ok  = 1'b1;
    end
    // widen before the product so slot 31 of 32-bit slots does not wrap
    slot_start = IDX_W'(slot_eff) * IDX_W'(wl);
    slot_end   = {1'b0, slot_start} + {{(IDX_W-5){1'b0}}, wl};
    active     = (st.state == LINK_FRAME) && half_ok &&
                 (lead_idx >= slot_start) && ({1'b0, lead_idx} < slot_end);
    bitpos     = 5'(lead_idx - slot_start);
    load_word  = fifo_link.out_valid ? fifo_link.out_data : '0;
    tx_bit     = (bitpos == 5'h00) ? load_word[SAMPLE_W-1]
                                   : st.word[SAMPLE_W-1-bitpos];
  end

  always_comb begin
    next_st     = st;
    next_st.pop = 1'b0;
    // synchronisers: the first stage feeds only the second
    next_st.bclk_s1  = bclk;
    next_st.bclk_s2  = st.bclk_s1;
    next_st.bclk_d   = st.bclk_s2;
    next_st.fsync_s1 = fsync;
    next_st.fsync_s2 = st.fsync_s1;

    // register port
    if (reg_write) begin
      if (reg_addr == CH2_CFG_ADDR) begin
        next_st.ch2_cfg = reg_wdata & CH2_CFG_WMASK;
      end else if (reg_addr == PIN_SEL_ADDR) begin
        next_st.channel2_pin_select = reg_wdata[CH2_PIN_BIT];
      end else if (reg_addr == FORMAT_ADDR) begin
        next_st.fmt     = reg_wdata[FMT_LSB +: 2];
        next_st.wl_code = reg_wdata[WL_LSB +: 2];
      end
    end
    next_st.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr == CH2_CFG_ADDR) begin
        next_st.rdata = st.ch2_cfg;
      end else if (reg_addr == PIN_SEL_ADDR) begin
        next_st.rdata[CH2_PIN_BIT] = st.channel2_pin_select;
      end else if (reg_addr == FORMAT_ADDR) begin
        next_st.rdata[FMT_LSB +: 2] = st.fmt;
        next_st.rdata[WL_LSB +: 2]  = st.wl_code;
      end else if (reg_addr == STATUS_ADDR) begin
        next_st.rdata[STAT_FRAME]    = (st.state == LINK_FRAME);
        next_st.rdata[STAT_FULL]     = !fifo_link.in_ready;
        next_st.rdata[STAT_UNDERRUN] = st.underrun;
        next_st.underrun             = 1'b0;
      end
    end

    // frame tracking on bit clock rising edges
    if (rise) begin
      next_st.fsync_prev = st.fsync_s2;
      if (frame_event) begin
        next_st.count  = '0;
        next_st.period = st.count + 1'b1;
        next_st.half   = (st.fmt == FMT_LJ) ? !st.fsync_s2 : st.fsync_s2;
        case (st.state)
          LINK_WAIT:  next_st.state = LINK_FRAME;
          LINK_FRAME: next_st.state = LINK_FRAME;
          default:    next_st.state = LINK_WAIT;
        endcase
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end

    // launch on falling edges so the host samples a settled bit
    if (fall) begin
      next_st.out1    = 1'b0;
      next_st.out2    = 1'b0;
      next_st.out1_oe = 1'b0;
      next_st.out2_oe = 1'b0;
      if (channel2_output_enable && active) begin
        if (bitpos == 5'h00) begin
          next_st.word = load_word;
          next_st.pop  = fifo_link.out_valid;
          if (!fifo_link.out_valid) begin
            next_st.underrun = 1'b1;
          end
        end
        if (st.channel2_pin_select) begin
          next_st.out2    = tx_bit;
          next_st.out2_oe = 1'b1;
        end else begin
          next_st.out1    = tx_bit;
          next_st.out1_oe = 1'b1;
        end
      end
    end
    // a disabled channel lets go of both pins at once
    if (!channel2_output_enable) begin
      next_st.out1_oe = 1'b0;
      next_st.out2_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st                     <= '0;
      st.ch2_cfg             <= CH2_CFG_RESET;
      st.channel2_pin_select <= PIN_SEL_RESET[CH2_PIN_BIT];
      st.fmt                 <= FORMAT_RESET[FMT_LSB +: 2];
      st.wl_code             <= FORMAT_RESET[WL_LSB +: 2];
      st.state               <= LINK_WAIT;
    end else begin
      st <= next_st;
    end
  end

  sequence s_fall_in_slot;
    fall && channel2_output_enable && active;
  endsequence

  sequence s_disabled_two;
    !channel2_output_enable [*2];
  endsequence

  a_reset_value: assert property (@(posedge clk_sys)
    !rst_n |=> (st.ch2_cfg == CH2_CFG_RESET))
    else $error("config reset value wrong");

  a_slot_reset: assert property (@(posedge clk_sys)
    !rst_n |=> (channel2_slot_select == 5'h01) && channel2_output_enable)
    else $error("slot select reset wrong");

  a_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_read && reg_addr == CH2_CFG_ADDR |=> reg_rdata == $past(st.ch2_cfg))
    else $error("config read data wrong");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_write && reg_addr == CH2_CFG_ADDR
      |=> st.ch2_cfg == {2'b00, $past(reg_wdata[5:0])})
    else $error("reserved bits not zero");

  a_tristate_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_disabled_two |-> !first_data_output_oe && !second_data_output_oe)
    else $error("disabled channel drives a pin");

  a_drive_slot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_fall_in_slot ##1 channel2_output_enable
      |-> first_data_output_oe || second_data_output_oe)
    else $error("enabled slot not driven");

  a_left_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fall && (st.fmt == FMT_I2S || st.fmt == FMT_LJ) &&
      !channel2_slot_select[HALF_BIT] && lead_half
      |=> !first_data_output_oe && !second_data_output_oe)
    else $error("left slot driven in right half");

  a_right_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fall && (st.fmt == FMT_I2S || st.fmt == FMT_LJ) &&
      channel2_slot_select[HALF_BIT] && !lead_half
      |=> !first_data_output_oe && !second_data_output_oe)
    else $error("right slot driven in left half");

  a_pin_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_fall_in_slot and st.channel2_pin_select
      |=> second_data_output_oe && !first_data_output_oe)
    else $error("channel on wrong data pin");

  a_pin_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_fall_in_slot and !st.channel2_pin_select
      |=> first_data_output_oe && !second_data_output_oe)
    else $error("channel on wrong first pin");

  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");

endmodule : serial_tx_ch2

// >>> serial_tx_ch2_pkg.sv
// constants, register map and types of the channel 2 transmit slot logic
package serial_tx_ch2_pkg;

  localparam logic [7:0] CH2_CFG_ADDR  = 8'h1f;
  localparam logic [7:0] PIN_SEL_ADDR  = 8'h1d;
  localparam logic [7:0] FORMAT_ADDR   = 8'h40;
  localparam logic [7:0] STATUS_ADDR   = 8'h41;

  localparam logic [7:0] CH2_CFG_RESET = 8'h21;
  localparam logic [7:0] PIN_SEL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET  = 8'h0c;

  localparam logic [7:0] CH2_CFG_WMASK = 8'h3f;
  localparam int         CH2_EN_BIT    = 5;
  localparam int         SLOT_LSB      = 0;
  localparam int         SLOT_W        = 5;
  localparam int         HALF_BIT      = 4;
  localparam int         CH2_PIN_BIT   = 1;
  localparam int         FMT_LSB       = 0;
  localparam int         WL_LSB        = 2;
  localparam int         STAT_FRAME    = 0;
  localparam int         STAT_FULL     = 1;
  localparam int         STAT_UNDERRUN = 2;

  localparam int         SAMPLE_BITS   = 32;
  localparam int         FIFO_DEPTH    = 16;
  localparam int         IDX_W         = 11;

  typedef enum logic [1:0] {
    FMT_TDM = 2'h0,
    FMT_I2S = 2'h1,
    FMT_LJ  = 2'h2
  } frame_format_t;

  typedef enum logic [1:0] {
    LINK_WAIT  = 2'b01,
    LINK_FRAME = 2'b10
  } link_state_t;

  // word length code to slot width in bit clocks
  function automatic logic [5:0] word_bits(input logic [1:0] code);
    case (code)
      2'h0:    word_bits = 6'h10;
      2'h1:    word_bits = 6'h14;
      2'h2:    word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction : word_bits

endpackage : serial_tx_ch2_pkg

// >>> serial_tx_ch2_tb.sv
// self-checking bench of the channel 2 transmit slot logic
`timescale 1ns/1ps
module serial_tx_ch2_tb;
  import serial_tx_ch2_pkg::*;

  typedef struct packed {
    logic [1:0]  f;
    logic [1:0]  w;
    logic [4:0]  s;
    logic        en;
    logic        pin;
    logic [15:0] n;
  } scen_t;

  logic        clk_sys;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic        bclk;
  logic        fsync;
  logic [31:0] sample_data;
  logic        sample_valid;
  logic        sample_ready;
  logic        first_data_output;
  logic        first_data_output_oe;
  logic        second_data_output;
  logic        second_data_output_oe;
  int          num_errors;
  int          num_checks;
  int          seed;
  logic [31:0] words [$];
  // frames stay short where the slot allows it, to keep the run brief
  scen_t       scens [8] = '{'{2'h0, 2'h3, 5'h01, 1'b1, 1'b0, 16'h48},
                             '{2'h3, 2'h0, 5'h00, 1'b1, 1'b1, 16'h40},
                             '{2'h0, 2'h0, 5'h0f, 1'b1, 1'b0, 16'h104},
                             '{2'h0, 2'h0, 5'h11, 1'b1, 1'b1, 16'h12c},
                             '{2'h0, 2'h0, 5'h03, 1'b0, 1'b0, 16'h40},
                             '{2'h1, 2'h0, 5'h10, 1'b1, 1'b0, 16'h80},
                             '{2'h1, 2'h2, 5'h01, 1'b1, 1'b1, 16'h80},
                             '{2'h2, 2'h0, 5'h11, 1'b1, 1'b0, 16'h80}};

  serial_tx_ch2 i_serial_tx_ch2 (
    .clk_sys               (clk_sys),
    .rst_n                 (rst_n),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_write             (reg_write),
    .reg_read              (reg_read),
    .reg_rdata             (reg_rdata),
    .bclk                  (bclk),
    .fsync                 (fsync),
    .sample_data           (sample_data),
    .sample_valid          (sample_valid),
    .sample_ready          (sample_ready),
    .first_data_output     (first_data_output),
    .first_data_output_oe  (first_data_output_oe),
    .second_data_output    (second_data_output),
    .second_data_output_oe (second_data_output_oe)
  );

  host_link_model i_host_link_model (
    .bclk                  (bclk),
    .fsync                 (fsync),
    .first_data_output     (first_data_output),
    .first_data_output_oe  (first_data_output_oe),
    .second_data_output    (second_data_output),
    .second_data_output_oe (second_data_output_oe)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    check(32'(reg_rdata), 32'(e));
  endtask : rd_chk

  // bit index of the msb: i2s has a one-bit delay, left-justified none
  function automatic int exp_first(input logic [1:0] f, input int s, input int n, input int b);
    int base;
    base = (f == 2'h2) ? 0 : 1;
    if (f == 2'h0 || f == 2'h3 || s < 16) begin
      return s * b + base;
    end
    return n / 2 + (s - 16) * b + base;
  endfunction : exp_first

  // slot width in bit clocks for a word length code
  function automatic int slot_bits(input logic [1:0] code);
    return (code == 2'h3) ? 32 : 16 + 4 * int'(code);
  endfunction : slot_bits

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #600_000;
    num_errors++;
    end_of_test();
  end

  initial begin
    logic [7:0]  v;
    logic [31:0] w;
    scen_t       sc;
    int          p;
    int          b;
    num_errors   = 0;
    num_checks   = 0;
    seed         = 2;
    rst_n        = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    reg_write    = 1'b0;
    reg_read     = 1'b0;
    sample_data  = 32'h0;
    sample_valid = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(CH2_CFG_ADDR, CH2_CFG_RESET);
    rd_chk(PIN_SEL_ADDR, PIN_SEL_RESET);
    rd_chk(FORMAT_ADDR, FORMAT_RESET);
    rd_chk(8'h55, 8'h00);
    @(posedge clk_sys);
    #1;
    check(32'(reg_rdata), 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      wr(CH2_CFG_ADDR, v);
      rd_chk(CH2_CFG_ADDR, v & 8'h3f);
    end
    // channel enabled but no frames yet, so the fifo only fills
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      @(posedge clk_sys);
      w = $random(seed);
      sample_valid <= 1'b1;
      sample_data  <= w;
      words.push_back(w);
    end
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    sample_data  <= ~w;
    @(posedge clk_sys);
    #1;
    check(32'(sample_ready), 32'h0);
    rd_chk(STATUS_ADDR, 8'h02);
    // a disabled lead-in frame locks the framing without using a sample
    for (int k = 0; k < 8; k++) begin
      sc = scens[k];
      p  = int'(sc.pin);
      b  = slot_bits(sc.w);
      wr(FORMAT_ADDR, {4'h0, sc.w, sc.f});
      wr(PIN_SEL_ADDR, {6'h00, sc.pin, 1'b0});
      wr(CH2_CFG_ADDR, {3'h0, sc.s});
      i_host_link_model.frame(int'(sc.n), sc.f);
      wr(CH2_CFG_ADDR, {2'h0, sc.en, sc.s});
      i_host_link_model.frame(int'(sc.n), sc.f);
      check(i_host_link_model.cnt[p], sc.en ? b : 0);
      check(i_host_link_model.cnt[1 - p], 0);
      if (sc.en) begin
        w = words.pop_front();
        check(i_host_link_model.cap[p], w >> (32 - b));
        check(i_host_link_model.first[p], exp_first(sc.f, int'(sc.s), int'(sc.n), b));
      end
    end
    // framed, fifo part drained, no underrun
    rd_chk(STATUS_ADDR, 8'h01);
    end_of_test();
  end
endmodule : serial_tx_ch2_tb
